// File: bench/rwst_asserts.sv
// Purpose: link handshake checks for the transmitter ends
// Assumes: small host variant, one clock domain
// Notes: sees only the link signals
`timescale 1ns/1ps
module rwst_asserts #(
   parameter int MIN_WORD = 192
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // link
   input wire logic func_ready,
   input wire logic out_ready,
   input wire logic out_resume
);
   logic [15:0] wcyc_q;
   logic [15:0] wcyc_d;

   // cycles the current word request has been up, saturating
   always_comb begin
      wcyc_d = !out_ready ? 16'h0000 : ((&wcyc_q) ? wcyc_q : wcyc_q + 16'h0001);
   end
   always_ff @(posedge core_clk_i) begin
      wcyc_q <= rst_n_i ? wcyc_d : 16'h0000;
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   property p_fr_answer;
      func_ready && !out_ready |-> ##[1:3] out_resume;
   endproperty
   a_fr_answer: assert property (p_fr_answer) else $error("no resume after function ready");
   property p_fr_release;
      $fell(func_ready) && !out_ready |-> ##[1:2] !out_resume;
   endproperty
   a_fr_release: assert property (p_fr_release) else $error("resume held after function ready fell");
   property p_fr_hold;
      out_resume && func_ready ##1 func_ready |-> out_resume;
   endproperty
   a_fr_hold: assert property (p_fr_hold) else $error("resume dropped while function ready held");
   property p_idle_quiet;
      !func_ready && !out_ready ##1 !func_ready && !out_ready |-> !out_resume;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("resume without a request");
   property p_resume_cause;
      $rose(out_resume) |-> func_ready || out_ready;
   endproperty
   a_resume_cause: assert property (p_resume_cause) else $error("resume rose with no request up");
   property p_word_bound;
      $rose(out_ready) && !func_ready |-> ##[1:1000] out_resume;
   endproperty
   a_word_bound: assert property (p_word_bound) else $error("word never answered");
   property p_word_len;
      $rose(out_resume) && out_ready |-> wcyc_q >= 16'(MIN_WORD);
   endproperty
   a_word_len: assert property (p_word_len) else $error("word answered before 24 bit times");
   property p_word_release;
      $fell(out_ready) && !func_ready |-> ##[1:2] !out_resume;
   endproperty
   a_word_release: assert property (p_word_release) else $error("resume held after word request fell");
endmodule // rwst_asserts

// File: bench/testbench.sv
// Purpose: end-to-end bench for host and transmitter ends
// Assumes: small variant, divider half period of four cycles
// Notes: serial words are decoded from the line outputs
`timescale 1ns/1ps
module testbench;
   import rwst_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sel_req = 1'b0;
   logic [1:0] sel_line = 2'h0;
   logic in_valid = 1'b0;
   logic [12:0] in_data = 13'h0000;
   logic [15:0] wgap = 16'h0010;
   logic [15:0] bgap = 16'h0040;
   logic w_ready, sel_done, xmit_sel, data_ready;
   logic [3:0] line, line_oe;
   logic [3:0] line_q = 4'h0;
   int failures = 0;
   int n_compared = 0;
   int cyc = 0;
   int n_acc = 0;
   int k, t0, t1;
   bit ok;

   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      line_q <= line;
   end

   rwst_link_if u_rwst_link_if ();
   rwst_host u_rwst_host (.core_clk_i(clk), .rst_n_i(rst_n), .sel_req_i(sel_req), .sel_line_i(sel_line),
      .word_valid_i(in_valid), .word_i(in_data[11:0]), .word_last_i(in_data[12]), .word_ready_o(w_ready),
      .sel_done_o(sel_done), .link(u_rwst_link_if.host));
   rwst_dev u_rwst_dev (.core_clk_i(clk), .rst_n_i(rst_n), .div_half_i(16'h0003), .word_gap_adjust_i(wgap),
      .block_gap_adjust_i(bgap), .line_o(line), .line_oe_o(line_oe), .xmit_sel_o(xmit_sel),
      .data_ready_o(data_ready), .link(u_rwst_link_if.dev));
   rwst_asserts #(.MIN_WORD(192)) u_rwst_asserts (.core_clk_i(clk), .rst_n_i(rst_n),
      .func_ready(u_rwst_link_if.func_ready), .out_ready(u_rwst_link_if.out_ready),
      .out_resume(u_rwst_link_if.out_resume));

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic print_verdict;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic select_line(input logic [1:0] ln);
      int i;
      sel_line = ln;
      sel_req = 1'b1;
      @(posedge clk);
      #1 sel_req = 1'b0;
      for (i = 0; i < 300 && sel_done !== 1'b1; i++) @(posedge clk);
      if (i == 300) begin
         failures++;
         print_verdict();
      end
      @(posedge clk);
      #1;
      chk({23'h0, xmit_sel}, 24'h1);
   endtask

   task automatic push(input logic [12:0] d, output bit acc);
      int i;
      in_valid = 1'b1;
      in_data = d;
      acc = 1'b0;
      for (i = 0; i < 300 && !acc; i++) begin
         @(posedge clk);
         acc = (w_ready === 1'b1);
      end
      #1 in_valid = 1'b0;
      if (!acc) begin
         failures++;
         print_verdict();
      end
   endtask

   // aligns on the odd-to-even fall of bit 0, so data words keep bit 0 set
   task automatic recv(input logic [1:0] ln, input logic [11:0] exp, output int ts);
      logic [23:0] got, hi;
      logic [3:0] oth;
      int i;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (i < 1200 && !(line_oe[ln] === 1'b1 && line_q[ln] === 1'b1 && line[ln] === 1'b0));
      if (i == 1200) begin
         failures++;
         print_verdict();
      end
      ts = cyc;
      chk({23'h0, data_ready}, 24'h1);
      got = 24'h0;
      hi = 24'h000001;
      oth = 4'h0;
      repeat (2) @(posedge clk);
      for (i = 0; i < 24; i++) begin
         got[i] = ~line[ln];
         oth = oth | (line_oe & ~(4'h1 << ln));
         if (i < 23) begin
            repeat (4) @(posedge clk);
            hi[i+1] = line[ln];
            repeat (4) @(posedge clk);
         end
      end
      chk(got, {exp, exp});
      chk(hi, 24'hffffff);
      chk({20'h0, oth}, 24'h0);
      #1;
   endtask

   initial begin
      repeat (20) @(posedge clk);
      #1 rst_n = 1'b1;
      @(posedge clk);
      #1;
      for (int l = 0; l < 4; l++) begin
         select_line(2'(l));
         push({1'b1, 12'h5a1 + 12'(2 * l)}, ok);
         chk({23'h0, ok}, 24'h1);
         recv(2'(l), 12'h5a1 + 12'(2 * l), t0);
         for (k = 0; k < 400 && u_rwst_link_if.out_ready !== 1'b0; k++) @(posedge clk);
         chk({23'h0, u_rwst_link_if.out_ready}, 24'h0);
         #1;
      end
      // six words on one line with stretched gaps; word 3 ends the block
      wgap = 16'h0028;
      bgap = 16'h0078;
      select_line(2'h1);
      for (k = 0; k < 6; k++) begin
         push({k == 3, 12'h5a1 + 12'(2 * k)}, ok);
         if (ok) n_acc++;
         recv(2'h1, 12'h5a1 + 12'(2 * k), t1);
         if (k > 0) chk({23'h0, t1 - t0 >= 192 + (k == 4 ? 116 : 36)}, 24'h1);
         t0 = t1;
      end
      for (k = 0; k < 400 && u_rwst_link_if.out_ready !== 1'b0; k++) @(posedge clk);
      chk({23'h0, n_acc == 6}, 24'h1);
      chk({23'h0, u_rwst_link_if.out_ready}, 24'h0);
      print_verdict();
   end

   initial begin
      repeat (100000) @(posedge clk);
      failures++;
      print_verdict();
   end
endmodule // testbench

// File: hdl/rwst_dev.sv
// Purpose: terminal end: stages host words and sends them as 24-bit redundant serial words
// Assumes: host keeps the channel rules; one clock
// Notes: a FIFO of staged words sits between capture and the serializer
`timescale 1ns/1ps
module rwst_dev #(
   parameter rwst_pkg::rwst_variant_t VARIANT = rwst_pkg::RWST_SMALL,
   parameter int FIFO_DEPTH = rwst_pkg::RWST_FIFO_DEPTH
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // timing adjustments
   input wire logic [rwst_pkg::RWST_CNT_W-1:0] div_half_i,
   input wire logic [rwst_pkg::RWST_CNT_W-1:0] word_gap_adjust_i,
   input wire logic [rwst_pkg::RWST_CNT_W-1:0] block_gap_adjust_i,
   // serial lines
   output logic [rwst_pkg::RWST_LINES-1:0] line_o,
   output logic [rwst_pkg::RWST_LINES-1:0] line_oe_o,
   // status
   output logic xmit_sel_o,
   output logic data_ready_o,
   // link
   rwst_link_if.dev link
);
   import rwst_pkg::*;
   typedef enum logic [2:0] {RWST_D_IDLE, RWST_D_ARM, RWST_D_SYNC, RWST_D_SEND, RWST_D_GAP} rwst_dstate_t;
   rwst_dstate_t st_q, st_d;
   logic xsel_q, xsel_d, res_q, res_d, fres_q, fres_d;
   logic [RWST_LINE_W-1:0] line_q, line_d;
   logic [RWST_CNT_W-1:0] div_q, div_d, gap_q, gap_d;
   logic odd_q, odd_d, even_q, even_d, ph_q, ph_d;
   logic [RWST_CNT_W-1:0] set_q, set_d;
   logic cap_q, cap_d, pend_q, pend_d, took_q, took_d;
   logic [RWST_WORD_W-1:0] stage_q, stage_d, hold_q, hold_d;
   logic blk_q, blk_d, hblk_q, hblk_d;
   logic ten_q, ten_d, sync_q, sync_d, schk_q, schk_d, den_q, den_d, drdy_q, drdy_d, mix_q, mix_d;
   logic [4:0] bit_q, bit_d;
   logic in_rdy, f_valid, f_ready;
   logic [RWST_WORD_W:0] f_data;
   logic fc_hit, cur_bit;
   rwst_fifo #(.WIDTH(RWST_WORD_W + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(cap_q),
      .in_data_i({blk_q, stage_q}),
      .in_ready_o(in_rdy),
      .out_valid_o(f_valid),
      .out_data_o(f_data),
      .out_ready_i(f_ready)
   );
   always_comb begin
      fc_hit = link.func_code[RWST_FUNC_W-1:RWST_LINE_W] == RWST_FC_XMIT;
      // bit counter runs up from 0 to 23: second half repeats bits in the same order
      cur_bit = hold_q[(bit_q < RWST_BITS_HALF) ? bit_q[3:0] : 4'(bit_q - RWST_BITS_HALF)];
      f_ready = (st_q == RWST_D_ARM) && xsel_q;
      xsel_d = xsel_q;
      line_d = line_q;
      if (link.func_ready) begin
         xsel_d = fc_hit;
         if (fc_hit) begin
            line_d = link.func_code[RWST_LINE_W-1:0];
         end
         fres_d = (VARIANT == RWST_SMALL);
      end else begin
         fres_d = 1'b0;
      end
      // divider: alternating odd and even phase pulses
      div_d = div_q + 1'b1;
      odd_d = 1'b0;
      even_d = 1'b0;
      ph_d = ph_q;
      if (div_q >= div_half_i) begin
         div_d = '0;
         ph_d = !ph_q;
         odd_d = !ph_q;
         even_d = ph_q;
      end
      // capture after settle; stalls while the FIFO is full
      set_d = set_q;
      pend_d = pend_q;
      took_d = took_q;
      cap_d = 1'b0;
      stage_d = stage_q;
      blk_d = blk_q;
      if (link.out_ready && !pend_q && !took_q && !res_q && xsel_q) begin
         pend_d = 1'b1;
         set_d = '0;
      end else if (pend_q) begin
         set_d = set_q + 1'b1;
         if (set_q >= RWST_CNT_W'(RWST_SETTLE_CYC) && in_rdy) begin
            stage_d = link.out_data;
            blk_d = link.block_end;
            cap_d = 1'b1;
            pend_d = 1'b0;
            took_d = 1'b1;
         end
      end
      if (!link.out_ready) begin
         took_d = 1'b0;
      end
      st_d = st_q;
      hold_d = hold_q;
      hblk_d = hblk_q;
      ten_d = ten_q;
      sync_d = sync_q;
      schk_d = schk_q;
      den_d = den_q;
      drdy_d = drdy_q;
      mix_d = mix_q;
      bit_d = bit_q;
      gap_d = gap_q;
      res_d = res_q;
      if (res_q && !link.out_ready) begin
         res_d = 1'b0;
      end
      unique case (st_q)
         RWST_D_IDLE: st_d = RWST_D_ARM;
         RWST_D_ARM: begin
            if (f_valid && xsel_q) begin
               hold_d = f_data[RWST_WORD_W-1:0];
               hblk_d = f_data[RWST_WORD_W];
               st_d = RWST_D_SYNC;
            end
         end
         RWST_D_SYNC: begin
            if (odd_q) begin
               ten_d = 1'b1;
            end
            if (ten_q && even_q) begin
               sync_d = 1'b1;
            end
            if (sync_q && odd_q) begin
               schk_d = 1'b1;
               den_d = 1'b1;
               bit_d = '0;
               mix_d = 1'b1;
               st_d = RWST_D_SEND;
            end
         end
         RWST_D_SEND: begin
            drdy_d = den_q;
            if (even_q) begin
               mix_d = !cur_bit;
            end
            if (odd_q) begin
               mix_d = 1'b1;
               bit_d = bit_q + 1'b1;
               if (bit_q == RWST_BITS_WORD - 5'h01) begin
                  hold_d = '0;
                  stage_d = cap_d ? stage_d : '0;
                  ten_d = 1'b0;
                  sync_d = 1'b0;
                  schk_d = 1'b0;
                  den_d = 1'b0;
                  drdy_d = 1'b0;
                  res_d = 1'b1;
                  gap_d = hblk_q ? block_gap_adjust_i : word_gap_adjust_i;
                  st_d = RWST_D_GAP;
               end
            end
         end
         RWST_D_GAP: begin
            gap_d = gap_q - 1'b1;
            if (gap_q == '0) begin
               st_d = RWST_D_ARM;
            end
         end
         default: st_d = RWST_D_IDLE;
      endcase
      fres_d = fres_d | res_d;
   end
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         st_q <= RWST_D_IDLE;
         xsel_q <= 1'b0;
         res_q <= 1'b0;
         fres_q <= 1'b0;
         line_q <= '0;
         div_q <= '0;
         gap_q <= '0;
         odd_q <= 1'b0;
         even_q <= 1'b0;
         ph_q <= 1'b0;
         set_q <= '0;
         cap_q <= 1'b0;
         pend_q <= 1'b0;
         took_q <= 1'b0;
         stage_q <= '0;
         hold_q <= '0;
         blk_q <= 1'b0;
         hblk_q <= 1'b0;
         ten_q <= 1'b0;
         sync_q <= 1'b0;
         schk_q <= 1'b0;
         den_q <= 1'b0;
         drdy_q <= 1'b0;
         mix_q <= 1'b0;
         bit_q <= '0;
      end else begin
         st_q <= st_d;
         xsel_q <= xsel_d;
         res_q <= res_d;
         fres_q <= fres_d;
         line_q <= line_d;
         div_q <= div_d;
         gap_q <= gap_d;
         odd_q <= odd_d;
         even_q <= even_d;
         ph_q <= ph_d;
         set_q <= set_d;
         cap_q <= cap_d;
         pend_q <= pend_d;
         took_q <= took_d;
         stage_q <= stage_d;
         hold_q <= hold_d;
         blk_q <= blk_d;
         hblk_q <= hblk_d;
         ten_q <= ten_d;
         sync_q <= sync_d;
         schk_q <= schk_d;
         den_q <= den_d;
         drdy_q <= drdy_d;
         mix_q <= mix_d;
         bit_q <= bit_d;
      end
   end
   // per-line drive registers
   logic [RWST_LINES-1:0] ln_q, ln_d, oe_q, oe_d;
   always_comb begin
      for (int i = 0; i < RWST_LINES; i++) begin
         oe_d[i] = den_q && (line_q == RWST_LINE_W'(i));
         ln_d[i] = oe_d[i] && mix_q;
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         ln_q <= '0;
         oe_q <= '0;
      end else begin
         ln_q <= ln_d;
         oe_q <= oe_d;
      end
   end
   assign line_o = ln_q;
   assign line_oe_o = oe_q;
   assign xmit_sel_o = xsel_q;
   assign data_ready_o = drdy_q;
   assign link.out_resume = fres_q;
endmodule // rwst_dev

// File: hdl/rwst_fifo.sv
// Purpose: valid/ready word buffer
// Assumes: depth is a power of two
// Notes: full and empty from pointer difference
`timescale 1ns/1ps
module rwst_fifo #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // fill side
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   // drain side
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q, wr_d, rd_q, rd_d;
   logic push, pop;
   always_comb begin
      push = in_valid_i && in_ready_o;
      pop = out_valid_o && out_ready_i;
      wr_d = wr_q + (AW+1)'(push);
      rd_d = rd_q + (AW+1)'(pop);
      in_ready_o = (wr_q - rd_q) != (AW+1)'(DEPTH);
      out_valid_o = wr_q != rd_q;
      out_data_o = mem_q[rd_q[AW-1:0]];
   end
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data_i;
      end
   end
endmodule // rwst_fifo

// File: hdl/rwst_host.sv
// Purpose: host end: selects transmit, then strobes words from a user FIFO
// Assumes: one word outstanding at a time
// Notes: variant picks pulsed or held function ready
`timescale 1ns/1ps
module rwst_host #(
   parameter rwst_pkg::rwst_variant_t VARIANT = rwst_pkg::RWST_SMALL
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // user side
   input wire logic sel_req_i,
   input wire logic [rwst_pkg::RWST_LINE_W-1:0] sel_line_i,
   input wire logic word_valid_i,
   input wire logic [rwst_pkg::RWST_WORD_W-1:0] word_i,
   input wire logic word_last_i,
   output logic word_ready_o,
   output logic sel_done_o,
   // link
   rwst_link_if.host link
);
   import rwst_pkg::*;
   typedef enum logic [2:0] {RWST_H_IDLE, RWST_H_FUNC, RWST_H_FDROP, RWST_H_WORD, RWST_H_WAIT} rwst_hstate_t;
   rwst_hstate_t st_q, st_d;
   logic [RWST_CNT_W-1:0] cnt_q, cnt_d;
   logic [RWST_FUNC_W-1:0] fc_q, fc_d;
   logic [RWST_WORD_W-1:0] dat_q, dat_d;
   logic fr_q, fr_d, or_q, or_d, be_q, be_d, rdy_q, rdy_d, done_q, done_d;
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      fc_d = fc_q;
      dat_d = dat_q;
      fr_d = fr_q;
      or_d = or_q;
      be_d = be_q;
      rdy_d = 1'b0;
      done_d = 1'b0;
      unique case (st_q)
         RWST_H_IDLE: begin
            if (sel_req_i) begin
               fc_d = {RWST_FC_XMIT, sel_line_i};
               cnt_d = '0;
               st_d = RWST_H_FUNC;
            end
         end
         RWST_H_FUNC: begin
            // lines settle one cycle before the ready
            fr_d = 1'b1;
            st_d = RWST_H_FDROP;
         end
         RWST_H_FDROP: begin
            cnt_d = cnt_q + 1'b1;
            if (VARIANT == RWST_LARGE && cnt_q == RWST_CNT_W'(RWST_FR_PULSE_CYC)) begin
               fr_d = 1'b0;
               done_d = 1'b1;
               st_d = RWST_H_WORD;
            end else if (VARIANT == RWST_SMALL && link.out_resume) begin
               fr_d = 1'b0;
               done_d = 1'b1;
               st_d = RWST_H_WORD;
            end
         end
         RWST_H_WORD: begin
            // a new select is taken only between words
            if (sel_req_i && !link.out_resume) begin
               fc_d = {RWST_FC_XMIT, sel_line_i};
               cnt_d = '0;
               st_d = RWST_H_FUNC;
            end else if (word_valid_i && !link.out_resume && !rdy_q) begin
               dat_d = word_i;
               be_d = word_last_i;
               rdy_d = 1'b1;
               or_d = 1'b1;
               st_d = RWST_H_WAIT;
            end
         end
         RWST_H_WAIT: begin
            if (link.out_resume) begin
               or_d = 1'b0;
               st_d = RWST_H_WORD;
            end
         end
         default: st_d = RWST_H_IDLE;
      endcase
   end
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         st_q <= RWST_H_IDLE;
         cnt_q <= '0;
         fc_q <= '0;
         dat_q <= '0;
         fr_q <= 1'b0;
         or_q <= 1'b0;
         be_q <= 1'b0;
         rdy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         fc_q <= fc_d;
         dat_q <= dat_d;
         fr_q <= fr_d;
         or_q <= or_d;
         be_q <= be_d;
         rdy_q <= rdy_d;
         done_q <= done_d;
      end
   end
   assign link.func_code = fc_q;
   assign link.func_ready = fr_q;
   assign link.out_data = dat_q;
   assign link.out_ready = or_q;
   assign link.block_end = be_q;
   assign word_ready_o = rdy_q;
   assign sel_done_o = done_q;
endmodule // rwst_host

// File: hdl/rwst_link_if.sv
// Purpose: parallel channel between host and transmitter
// Assumes: single clock
// Notes: modport per party
`timescale 1ns/1ps
interface rwst_link_if;
   import rwst_pkg::*;
   logic [RWST_FUNC_W-1:0] func_code;
   logic func_ready;
   logic [RWST_WORD_W-1:0] out_data;
   logic out_ready;
   logic out_resume;
   logic block_end;
   modport dev (input func_code, func_ready, out_data, out_ready, block_end, output out_resume);
   modport host (output func_code, func_ready, out_data, out_ready, block_end, input out_resume);
endinterface // rwst_link_if

// File: hdl/rwst_pkg.sv
// Purpose: shared constants and types for the redundant word serial transmitter
// Assumes: 200 MHz core clock
// Notes: function codes and timing defaults are plain values
package rwst_pkg;
   localparam int RWST_WORD_W = 12;
   localparam int RWST_FUNC_W = 12;
   localparam int RWST_LINES = 4;
   localparam int RWST_LINE_W = 2;
   localparam int RWST_FIFO_DEPTH = 16;
   // transmit-select code: upper bits match, low bits pick the line
   localparam logic [9:0] RWST_FC_XMIT = 10'h011;
   localparam int RWST_CLK_MHZ = 200;
   // host pulse width for the larger variant
   localparam int RWST_FR_PULSE_NS = 8000;
   localparam int RWST_FR_PULSE_CYC = (RWST_FR_PULSE_NS * RWST_CLK_MHZ) / 1000;
   // data line settling before capture
   localparam int RWST_SETTLE_NS = 50;
   localparam int RWST_SETTLE_CYC = (RWST_SETTLE_NS * RWST_CLK_MHZ + 999) / 1000;
   localparam int RWST_CNT_W = 16;
   localparam logic [RWST_CNT_W-1:0] RWST_DIV_DEF = 16'h0004;
   localparam logic [RWST_CNT_W-1:0] RWST_WGAP_DEF = 16'h0010;
   localparam logic [RWST_CNT_W-1:0] RWST_BGAP_DEF = 16'h0040;
   localparam logic [4:0] RWST_BITS_HALF = 5'h0c;
   localparam logic [4:0] RWST_BITS_WORD = 5'h18;
   typedef enum logic {RWST_LARGE, RWST_SMALL} rwst_variant_t;
endpackage
